// file: hdl/sms_pkg.sv
// Shared constants, configuration struct and state type of the serial
// peripheral controller. Assumes one 200 MHz system clock.
//
// Contract
// - Works as bus master driving clock and selects, or as bus slave.
// - Full duplex: one bit out and one bit in per serial clock.
// - Programmable polarity and phase; polarity sets serial clock idle level.
// - Modes 0 and 3 sample incoming data on the rising serial clock edge.
// - Modes 1 and 2 sample incoming data on the falling serial clock edge.
// - Modes 0 and 3 change outgoing data on the falling edge.
// - Modes 1 and 2 change outgoing data on the rising edge.
// - Transmit data is buffered in a 64 entry by 32 bit FIFO.
// - Packet length programmable 4 to 32 bits; exactly that many clocks.
// - Master inserts a programmable idle gap between packets.
// - Chip select is either a software level or hardware per packet.
package sms_pkg;

  // ==========================================================================
  // Sizes and counts
  localparam int unsigned WORD_W     = 32;
  localparam int unsigned FIFO_DEPTH = 64;
  localparam logic [5:0]  LEN_MIN    = 6'h04;
  localparam logic [5:0]  LEN_MAX    = 6'h20;
  // Half period floor: must exceed the three-flop input sampling delay
  localparam logic [7:0]  HALF_MIN   = 8'h04;

  // ==========================================================================
  // Reset values
  localparam logic [WORD_W-1:0] WORD_RST = 32'h0000_0000;
  localparam logic [7:0]        CNT_RST  = 8'h00;
  localparam logic [5:0]        EDGE_RST = 6'h00;

  // ==========================================================================
  // Configuration carried as one packed group
  typedef struct packed {
    logic       master;   // 1 master, 0 slave
    logic       cpol;     // serial clock idle level
    logic       cpha;     // 0 sample on leading edge
    logic       cs_hw;    // 1 hardware select per packet
    logic       cs_sel;   // 0 line a, 1 line b
    logic       cs_sw;    // software select level, 1 asserted
    logic [5:0] len;      // bits per packet
    logic [7:0] half;     // master half period in system clocks
    logic [7:0] gap;      // master idle clocks between packets
  } sms_cfg_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SETUP = 2'b01,
    ST_SHIFT = 2'b11,
    ST_GAP   = 2'b10
  } sms_state_t;

endpackage : sms_pkg

// file: hdl/sms_sync.sv
// Three-flop input synchroniser, one lane per bit.
// Assumes inputs from a foreign domain or pin; output on clock.
`timescale 1ns/1ps
module sms_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  // ==========================================================================
  // Stages
  logic [W-1:0] s1_q, s2_q, s3_q, out_q;
  logic [W-1:0] out_d;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_lane
      // Change is accepted only once stages two and three agree
      always_comb begin
        out_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : out_q[i];
      end
    end
  endgenerate

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      out_q <= '0;
    end else begin
      s1_q  <= async_in;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      out_q <= out_d;
    end
  end

  assign sync_out = out_q;

endmodule : sms_sync

// file: hdl/sms_fifo.sv
// Synchronous FIFO in flip-flops with valid/ready on both sides.
// Assumes one clock; depth a power of two.
`timescale 1ns/1ps
module sms_fifo #(
  parameter int unsigned W = 32,
  parameter int unsigned D = 64
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);

  localparam int unsigned AW = $clog2(D);

  // ==========================================================================
  // Storage and pointers
  logic [W-1:0] mem_q [D];
  logic [AW:0]  wp_q, wp_d, rp_q, rp_d;
  logic         push, pop;

  assign in_ready  = (wp_q - rp_q) != (AW+1)'(D);
  assign out_valid = wp_q != rp_q;
  assign out_data  = mem_q[rp_q[AW-1:0]];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb begin
    wp_d = push ? wp_q + 1'b1 : wp_q;
    rp_d = pop ? rp_q + 1'b1 : rp_q;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end

  // Data array needs no reset; only entries behind the pointers are read
  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wp_q[AW-1:0]] <= in_data;
    end
  end

endmodule : sms_fifo

// file: hdl/sms_ctrl.sv
// Serial peripheral controller top: master engine on the system clock,
// slave engine on the incoming serial clock, transmit FIFO, receive word.
// Assumes configuration is changed only while no packet is in progress.
`timescale 1ns/1ps
module sms_ctrl #(
  parameter int unsigned W = sms_pkg::WORD_W,
  parameter int unsigned D = sms_pkg::FIFO_DEPTH
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire sms_pkg::sms_cfg_t cfg,
  // Transmit words in
  input  wire logic              tx_valid,
  output logic                   tx_ready,
  input  wire logic [W-1:0]      tx_data,
  // Received words out
  output logic                   rx_valid,
  input  wire logic              rx_ready,
  output logic      [W-1:0]      rx_data,
  // Status
  output logic                   busy,
  output logic                   rx_overrun,
  input  wire logic              rx_overrun_clear,
  // Serial clock pin; also the link clock in slave operation
  input  wire logic              port_a_serial_clock_in,
  output logic                   port_a_serial_clock_out,
  output logic                   port_a_serial_clock_oe,
  input  wire logic              mosi_in,
  output logic                   mosi_out,
  output logic                   mosi_oe,
  input  wire logic              miso_in,
  output logic                   miso_out,
  output logic                   miso_oe,
  input  wire logic              port_a_select_line_a_in,
  output logic                   port_a_select_line_a_out,
  output logic                   port_a_select_line_a_oe,
  input  wire logic              port_a_select_line_b_in,
  output logic                   port_a_select_line_b_out,
  output logic                   port_a_select_line_b_oe
);

  // ==========================================================================
  // Effective configuration
  logic [5:0] len;
  logic [7:0] half;

  always_comb begin
    len = cfg.len;
    if (cfg.len < sms_pkg::LEN_MIN) begin
      len = sms_pkg::LEN_MIN;
    end else if (cfg.len > sms_pkg::LEN_MAX) begin
      len = sms_pkg::LEN_MAX;
    end
    half = (cfg.half < sms_pkg::HALF_MIN) ? sms_pkg::HALF_MIN : cfg.half;
  end

  // ==========================================================================
  // Transmit FIFO
  logic         fifo_valid;
  logic         fifo_pop;
  logic [W-1:0] fifo_word;

  sms_fifo #(
    .W (W),
    .D (D)
  ) u_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_word)
  );

  // Word aligned so that its first bit sits at the top
  logic [W-1:0] fifo_aligned;
  assign fifo_aligned = fifo_word << (6'(W) - len);

  // ==========================================================================
  // Link domain: slave engine on the incoming serial clock
  // Inverting the clock for modes 1 and 2 makes its rising edge the
  // sampling edge in every mode.
  logic slv_clk;
  logic slv_rst;
  assign slv_clk = port_a_serial_clock_in ^ (cfg.cpol ^ cfg.cpha);
  // Deselect holds the engine in reset, so stray clocks are ignored.
  // Hazard: this is a combinational reset; select must be glitch free.
  assign slv_rst = rst | port_a_select_line_a_in | cfg.master;

  logic [5:0]   lcnt_q, lcnt_d;
  logic [W-1:0] lrx_q, lrx_d;
  logic [W-1:0] lword_q, lword_d;
  logic         ltog_q, ltog_d;
  logic [5:0]   ltx_q, ltx_d;
  logic [W-1:0] stx_q;

  always_comb begin
    lrx_d   = {lrx_q[W-2:0], mosi_in};
    lcnt_d  = lcnt_q + 6'h01;
    lword_d = lword_q;
    ltog_d  = ltog_q;
    if (lcnt_q == len - 6'h01) begin
      lcnt_d  = sms_pkg::EDGE_RST;
      lword_d = lrx_d;
      ltog_d  = ~ltog_q;
    end
  end

  always_ff @(posedge slv_clk or posedge slv_rst) begin
    if (slv_rst) begin
      lcnt_q <= sms_pkg::EDGE_RST;
      lrx_q  <= sms_pkg::WORD_RST;
    end else begin
      lcnt_q <= lcnt_d;
      lrx_q  <= lrx_d;
    end
  end

  // Finished word survives deselect; only the system reset clears it
  always_ff @(posedge slv_clk or posedge rst) begin
    if (rst) begin
      lword_q <= sms_pkg::WORD_RST;
      ltog_q  <= 1'b0;
    end else begin
      lword_q <= lword_d;
      ltog_q  <= ltog_d;
    end
  end

  // Falling edge of the normalised clock is the changing edge
  always_comb begin
    ltx_d = (ltx_q == len - 6'h01) ? sms_pkg::EDGE_RST : ltx_q + 6'h01;
  end

  always_ff @(negedge slv_clk or posedge slv_rst) begin
    if (slv_rst) begin
      ltx_q <= sms_pkg::EDGE_RST;
    end else begin
      ltx_q <= ltx_d;
    end
  end

  // Phase 1 puts bit 0 out on the first leading edge, so lag by one.
  // stx_q is held steady by the system side across the packet.
  logic [5:0] lbit;
  always_comb begin
    lbit = ltx_q;
    if (cfg.cpha) begin
      lbit = (ltx_q == sms_pkg::EDGE_RST) ? len - 6'h01 : ltx_q - 6'h01;
    end
  end

  // ==========================================================================
  // Crossing into the system domain
  logic [1:0] sync_q;
  logic       miso_s;
  logic       ltog_s;
  logic       ltog_seen_q;
  logic       slv_done;

  sms_sync #(
    .W (2)
  ) u_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in ({miso_in, ltog_q}),
    .sync_out (sync_q)
  );

  assign miso_s   = sync_q[1];
  assign ltog_s   = sync_q[0];
  assign slv_done = ltog_s ^ ltog_seen_q;

  // ==========================================================================
  // Master engine
  sms_pkg::sms_state_t st_q, st_d;
  logic [7:0]   tmr_q, tmr_d;
  logic [5:0]   edge_q, edge_d;
  logic [W-1:0] sh_q, sh_d;
  logic [W-1:0] rx_q, rx_d;
  logic         sck_q, sck_d;
  logic         tail_q, tail_d;
  logic         mst_done;
  logic         mst_pop;
  logic         lead, samp;

  always_comb begin
    st_d     = st_q;
    tmr_d    = tmr_q;
    edge_d   = edge_q;
    sh_d     = sh_q;
    rx_d     = rx_q;
    sck_d    = sck_q;
    tail_d   = tail_q;
    mst_done = 1'b0;
    mst_pop  = 1'b0;
    lead     = ~edge_q[0];
    samp     = lead ^ cfg.cpha;
    case (st_q)
      sms_pkg::ST_IDLE: begin
        sck_d = cfg.cpol;
        if (cfg.master && fifo_valid) begin
          mst_pop = 1'b1;
          sh_d    = fifo_aligned;
          tmr_d   = half;
          st_d    = sms_pkg::ST_SETUP;
        end
      end
      sms_pkg::ST_SETUP: begin
        tmr_d = tmr_q - 8'h01;
        if (tmr_q == 8'h01) begin
          tmr_d  = half;
          edge_d = sms_pkg::EDGE_RST;
          st_d   = sms_pkg::ST_SHIFT;
        end
      end
      sms_pkg::ST_SHIFT: begin
        tmr_d = tmr_q - 8'h01;
        if (tmr_q == 8'h01 && tail_q) begin
          // Select stays half a period past the last edge: hold time
          tail_d = 1'b0;
          tmr_d  = cfg.gap;
          st_d   = sms_pkg::ST_GAP;
        end else if (tmr_q == 8'h01) begin
          tmr_d  = half;
          sck_d  = ~sck_q;
          edge_d = edge_q + 6'h01;
          if (samp) begin
            rx_d = {rx_q[W-2:0], miso_s};
          end else if (!(cfg.cpha && edge_q == sms_pkg::EDGE_RST)) begin
            sh_d = {sh_q[W-2:0], 1'b0};
          end
          if (edge_q == {len[4:0], 1'b0} - 6'h01) begin
            mst_done = 1'b1;
            tail_d   = 1'b1;
          end
        end
      end
      sms_pkg::ST_GAP: begin
        tmr_d = tmr_q - 8'h01;
        if (tmr_q == sms_pkg::CNT_RST || tmr_q == 8'h01) begin
          st_d = sms_pkg::ST_IDLE;
        end
      end
      default: begin
        st_d = sms_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q   <= sms_pkg::ST_IDLE;
      tmr_q  <= sms_pkg::CNT_RST;
      edge_q <= sms_pkg::EDGE_RST;
      sh_q   <= sms_pkg::WORD_RST;
      rx_q   <= sms_pkg::WORD_RST;
      sck_q  <= 1'b0;
      tail_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      tmr_q  <= tmr_d;
      edge_q <= edge_d;
      sh_q   <= sh_d;
      rx_q   <= rx_d;
      sck_q  <= sck_d;
      tail_q <= tail_d;
    end
  end

  // ==========================================================================
  // Slave transmit word and receive delivery
  logic         stx_have_q, stx_have_d;
  logic [W-1:0] stx_d;
  logic         slv_pop;
  logic         rxv_q, rxv_d;
  logic [W-1:0] rxd_q, rxd_d;
  logic         ovr_q, ovr_d;
  logic         done;
  logic [W-1:0] done_word;

  assign done      = mst_done | (slv_done & ~cfg.master);
  assign done_word = cfg.master ? rx_d : lword_q;
  // Limitation: back-to-back slave packets must leave a few system clocks
  // for the next word to be reloaded before its first bit goes out.
  assign slv_pop   = ~cfg.master & ~stx_have_q & fifo_valid;
  assign fifo_pop  = mst_pop | slv_pop;

  always_comb begin
    stx_have_d = stx_have_q;
    stx_d      = stx_q;
    if (slv_done) begin
      stx_have_d = 1'b0;
    end else if (slv_pop) begin
      stx_have_d = 1'b1;
      stx_d      = fifo_aligned;
    end
    rxv_d = rxv_q & ~rx_ready;
    rxd_d = rxd_q;
    ovr_d = ovr_q & ~rx_overrun_clear;
    if (done) begin
      rxv_d = 1'b1;
      rxd_d = done_word & ~({W{1'b1}} << len);
      // Set wins over a clear arriving in the same cycle
      if (rxv_q && !rx_ready) begin
        ovr_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ltog_seen_q <= 1'b0;
      stx_have_q  <= 1'b0;
      stx_q       <= sms_pkg::WORD_RST;
      rxv_q       <= 1'b0;
      rxd_q       <= sms_pkg::WORD_RST;
      ovr_q       <= 1'b0;
    end else begin
      ltog_seen_q <= ltog_s;
      stx_have_q  <= stx_have_d;
      stx_q       <= stx_d;
      rxv_q       <= rxv_d;
      rxd_q       <= rxd_d;
      ovr_q       <= ovr_d;
    end
  end

  // ==========================================================================
  // Pins
  logic cs_act;
  always_comb begin
    cs_act = cfg.cs_sw;
    if (cfg.cs_hw) begin
      cs_act = (st_q == sms_pkg::ST_SETUP) || (st_q == sms_pkg::ST_SHIFT);
    end
  end

  assign port_a_serial_clock_out  = sck_q;
  assign port_a_serial_clock_oe   = cfg.master;
  assign mosi_out                 = sh_q[W-1];
  assign mosi_oe                  = cfg.master;
  assign miso_out                 = stx_q[5'(6'(W-1) - lbit)];
  assign miso_oe                  = ~cfg.master &
                                    ~port_a_select_line_a_in;
  assign port_a_select_line_a_out = ~(cs_act & ~cfg.cs_sel);
  assign port_a_select_line_b_out = ~(cs_act & cfg.cs_sel);
  assign port_a_select_line_a_oe  = cfg.master;
  assign port_a_select_line_b_oe  = cfg.master;

  // ==========================================================================
  // Status
  assign rx_valid   = rxv_q;
  assign rx_data    = rxd_q;
  assign rx_overrun = ovr_q;
  assign busy       = cfg.master ? (st_q != sms_pkg::ST_IDLE)
                                 : ~port_a_select_line_a_in;

endmodule : sms_ctrl

// file: verif/sms_ctrl_assertions.sv
// Checker on the top ports of the serial controller: pins, selects, counts.
// Assumes a legal packet length and a configuration static while busy.
`timescale 1ns/1ps
module sms_chk (
  input wire logic              clock,
  input wire logic              rst,
  input wire sms_pkg::sms_cfg_t cfg,
  input wire logic              busy,
  input wire logic              rx_valid,
  input wire logic              rx_ready,
  input wire logic              port_a_serial_clock_out,
  input wire logic              port_a_serial_clock_oe,
  input wire logic              mosi_oe,
  input wire logic              miso_oe,
  input wire logic              port_a_select_line_a_in,
  input wire logic              port_a_select_line_a_out,
  input wire logic              port_a_select_line_b_out
);
  // ==========================================
  // Clock edges counted from the select falling
  logic       sel_low;
  logic       sel_q;
  logic       sck_q;
  logic [6:0] edge_q;
  assign sel_low = cfg.cs_sel ? !port_a_select_line_b_out
                              : !port_a_select_line_a_out;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sel_q  <= 1'b0;
      sck_q  <= 1'b0;
      edge_q <= 7'h00;
    end else begin
      sel_q <= sel_low;
      sck_q <= port_a_serial_clock_out;
      if (sel_low && !sel_q) begin
        edge_q <= 7'h00;
      end else if (sck_q != port_a_serial_clock_out) begin
        edge_q <= edge_q + 7'h01;
      end
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // ==========================================
  // Properties
  pin_dir_a : assert property (
    port_a_serial_clock_oe == cfg.master && mosi_oe == cfg.master)
    else $error("clock or data enable wrong for the role");
  sck_idle_a : assert property (
    cfg.master && !busy && !$past(busy) && $stable(cfg)
    |-> port_a_serial_clock_out == cfg.cpol)
    else $error("serial clock not at its idle level");
  edge_count_a : assert property (
    cfg.master && cfg.cs_hw && $fell(sel_low)
    |-> ##2 edge_q == {cfg.len, 1'b0})
    else $error("clock edge count differs from packet length");
  gap_hold_a : assert property (
    cfg.master && cfg.cs_hw && cfg.gap >= 8'h08 && $fell(sel_low)
    |-> !sel_low [*7])
    else $error("packet started inside the idle gap");
  sw_select_a : assert property (
    cfg.master && !cfg.cs_hw
    |-> port_a_select_line_a_out == !(cfg.cs_sw && !cfg.cs_sel)
     && port_a_select_line_b_out == !(cfg.cs_sw && cfg.cs_sel))
    else $error("software select level not on the pins");
  one_select_a : assert property (
    cfg.master |-> port_a_select_line_a_out || port_a_select_line_b_out)
    else $error("both select lines asserted");
  slave_float_a : assert property (
    miso_oe == (!cfg.master && !port_a_select_line_a_in))
    else $error("slave data enable wrong for its select");
  rx_hold_a : assert property (
    rx_valid && !rx_ready |=> rx_valid)
    else $error("received word dropped before it was taken");
endmodule : sms_chk

bind sms_ctrl sms_chk chk_u (
  .clock(clock), .rst(rst), .cfg(cfg), .busy(busy), .rx_valid(rx_valid),
  .rx_ready(rx_ready), .mosi_oe(mosi_oe), .miso_oe(miso_oe),
  .port_a_serial_clock_out(port_a_serial_clock_out),
  .port_a_serial_clock_oe(port_a_serial_clock_oe),
  .port_a_select_line_a_in(port_a_select_line_a_in),
  .port_a_select_line_a_out(port_a_select_line_a_out),
  .port_a_select_line_b_out(port_a_select_line_b_out));

// file: verif/sms_dev_model.sv
// Far-side serial device: shifts a reply out and collects one word in.
// Assumes its mode inputs change only while it is deselected.
`timescale 1ns/1ps
module sms_dev_model (
  input  wire logic        sck,
  input  wire logic        sel_n,
  input  wire logic        mosi,
  input  wire logic        cpol,
  input  wire logic        cpha,
  input  wire logic [5:0]  len,
  input  wire logic [31:0] reply,
  output logic             miso,
  output logic [31:0]      got,
  output logic [15:0]      cnt
);
  // ==========================================
  // Shifting on a normalised clock
  logic        e;
  logic        d_q = 1'b0;
  logic [31:0] sh_q;
  logic [31:0] in_q;
  logic [5:0]  n_q;
  initial got = 32'h0000_0000;
  initial cnt = 16'h0000;
  // Sampling edge rises and shifting edge falls in every mode
  assign e = sck ^ cpol ^ cpha;
  // Released line shows the inverse of its last bit, never a held value
  assign miso = sel_n ? ~d_q : d_q;
  always @(negedge sel_n) begin
    sh_q = reply << (32 - len);
    in_q = 32'h0000_0000;
    n_q = 6'h00;
    if (!cpha) begin
      d_q = sh_q[31];
      sh_q = sh_q << 1;
    end
  end
  always @(negedge e) begin
    if (!sel_n) begin
      d_q = sh_q[31];
      sh_q = sh_q << 1;
    end
  end
  always @(posedge e) begin
    if (!sel_n) begin
      in_q = {in_q[30:0], mosi};
      n_q = n_q + 6'h01;
      if (n_q == len) begin
        got = in_q;
        cnt = cnt + 16'h0001;
      end
    end
  end
endmodule : sms_dev_model

// file: verif/test_spi_master_slave_controller.sv
// Bench of the serial controller: master traffic in all modes against the
// device model, select schemes, a full buffer and one slave frame.
`timescale 1ns/1ps
`define CHECK(nm, ex, sn) begin checked++; if ((sn) !== (ex)) begin \
  errors++; $display("MISMATCH %s expected %0h seen %0h", nm, ex, sn); \
  end end
module test_spi_master_slave_controller;
  // ==========================================
  // Pins and wiring
  logic              clock = 1'b0;
  logic              rst = 1'b1;
  sms_pkg::sms_cfg_t cfg = {6'h24, 6'h08, 8'h06, 8'h08};
  logic              tx_valid = 1'b0;
  logic              rx_ready = 1'b1;
  logic              ovr_clr = 1'b0;
  logic              tb_sck = 1'b0;
  logic              tb_mosi = 1'b0;
  logic              tb_sa = 1'b1;
  logic [31:0]       tx_data = 32'h0000_0000;
  logic [31:0]       reply = 32'h0000_0000;
  logic [31:0]       rx_data, dev_got;
  logic [15:0]       dev_cnt;
  logic              tx_ready, rx_valid, busy, rx_overrun, dev_miso;
  logic              sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  logic              sa_o, sa_oe, sb_o, sb_oe, sck_w, mosi_w, miso_w;
  logic              sa_w, sb_w, dev_sel_n;
  int                errors = 0;
  int                checked = 0;
  always #2.5 clock = ~clock;
  assign sck_w = sck_oe ? sck_o : tb_sck;
  assign mosi_w = mosi_oe ? mosi_o : tb_mosi;
  assign miso_w = miso_oe ? miso_o : dev_miso;
  assign sa_w = sa_oe ? sa_o : tb_sa;
  // Line b has no other driver in slave operation
  assign sb_w = sb_oe ? sb_o : 1'b1;
  assign dev_sel_n = !cfg.master || (cfg.cs_sel ? sb_w : sa_w);
  sms_ctrl dut_u (
    .clock(clock), .rst(rst), .cfg(cfg), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .rx_data(rx_data), .busy(busy),
    .rx_overrun(rx_overrun), .rx_overrun_clear(ovr_clr),
    .port_a_serial_clock_in(sck_w), .port_a_serial_clock_out(sck_o),
    .port_a_serial_clock_oe(sck_oe), .mosi_in(mosi_w), .mosi_out(mosi_o),
    .mosi_oe(mosi_oe), .miso_in(miso_w), .miso_out(miso_o),
    .miso_oe(miso_oe), .port_a_select_line_a_in(sa_w),
    .port_a_select_line_a_out(sa_o), .port_a_select_line_a_oe(sa_oe),
    .port_a_select_line_b_in(sb_w), .port_a_select_line_b_out(sb_o),
    .port_a_select_line_b_oe(sb_oe));
  sms_dev_model dev_u (
    .sck(sck_w), .sel_n(dev_sel_n), .mosi(mosi_w), .cpol(cfg.cpol),
    .cpha(cfg.cpha), .len(cfg.len), .reply(reply), .miso(dev_miso),
    .got(dev_got), .cnt(dev_cnt));
  // ==========================================
  // Shared tasks
  function automatic logic [31:0] mask(input logic [5:0] ln);
    return (ln == 6'h20) ? 32'hffff_ffff : (32'h0000_0001 << ln) - 1;
  endfunction : mask
  // Flags: master, polarity, phase, hardware select, line b, soft level
  task automatic set_cfg(input logic [5:0] fl, input logic [5:0] ln,
                         input logic [7:0] hf, input logic [7:0] gp);
    cfg <= {fl, ln, hf, gp};
    repeat (3) @(posedge clock);
  endtask : set_cfg
  task automatic push(input logic [31:0] w);
    tx_valid <= 1'b1;
    tx_data <= w;
    do @(posedge clock); while (tx_ready !== 1'b1);
    tx_valid <= 1'b0;
  endtask : push
  task automatic wait_rx;
    for (int i = 0; i < 4000; i++) begin
      @(posedge clock);
      if (rx_valid === 1'b1) break;
    end
    `CHECK("rx_valid", 1'b1, rx_valid)
  endtask : wait_rx
  task automatic xfer(input logic [31:0] w, input logic [31:0] r);
    reply <= r;
    push(w);
    wait_rx;
    `CHECK("rx_data", r & mask(cfg.len), rx_data)
    `CHECK("dev_got", w & mask(cfg.len), dev_got)
    repeat (20) @(posedge clock);
    `CHECK("sck_idle", cfg.cpol, sck_w)
    `CHECK("busy", 1'b0, busy)
  endtask : xfer
  // ==========================================
  // Scenarios
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      set_cfg({1'b1, m[1], m[0], 1'b1, m[0], 1'b0}, 6'h08, 8'h06, 8'h08);
      xfer(32'h1234_56a5 ^ 32'(m), 32'h0000_00c3 ^ 32'(m << 4));
    end
    $display("modes test done");
  endtask : t_modes
  task automatic t_lengths;
    set_cfg(6'h24, 6'h04, 8'h06, 8'h08);
    xfer(32'hffff_fffa, 32'h0000_0005);
    set_cfg(6'h24, 6'h20, 8'h06, 8'h08);
    xfer(32'ha5c3_0f96, 32'h5a3c_f069);
    $display("lengths test done");
  endtask : t_lengths
  task automatic t_fill;
    int          acc;
    logic [15:0] c0;
    set_cfg(6'h24, 6'h04, 8'h06, 8'hff);
    rx_ready <= 1'b0;
    c0 = dev_cnt;
    acc = 0;
    tx_valid <= 1'b1;
    for (int i = 0; i < 70; i++) begin
      tx_data <= 32'(i);
      @(posedge clock);
      if (tx_ready === 1'b1) acc++;
    end
    tx_valid <= 1'b0;
    `CHECK("accepted", 65, acc)
    for (int i = 0; i < 25000 && dev_cnt != c0 + 16'h0041; i++)
      @(posedge clock);
    repeat (10) @(posedge clock);
    `CHECK("drained", c0 + 16'h0041, dev_cnt)
    `CHECK("overrun", 1'b1, rx_overrun)
    ovr_clr <= 1'b1;
    @(posedge clock);
    ovr_clr <= 1'b0;
    rx_ready <= 1'b1;
    repeat (2) @(posedge clock);
    `CHECK("overrun clear", 1'b0, rx_overrun)
    repeat (300) @(posedge clock);
    $display("fill test done");
  endtask : t_fill
  task automatic t_sw;
    for (int k = 0; k < 4; k++) begin
      set_cfg({4'h8, k[1], k[0]}, 6'h08, 8'h06, 8'h08);
      `CHECK("select a", !(k[0] && !k[1]), sa_w)
      `CHECK("select b", !(k[0] && k[1]), sb_w)
    end
    $display("soft select test done");
  endtask : t_sw
  task automatic t_slave;
    logic [7:0] sent;
    logic [7:0] seen;
    sent = 8'h96;
    seen = 8'h00;
    set_cfg(6'h04, 6'h08, 8'h06, 8'h02);
    rx_ready <= 1'b0;
    push(32'h0000_003c);
    repeat (10) @(posedge clock);
    // Stray clock while deselected, enough edges to fill a word
    repeat (16) #32 tb_sck = ~tb_sck;
    repeat (20) @(posedge clock);
    `CHECK("stray rx", 1'b0, rx_valid)
    tb_sa = 1'b0;
    #64;
    `CHECK("slave busy", 1'b1, busy)
    for (int i = 7; i >= 0; i--) begin
      tb_mosi = sent[i];
      #32 tb_sck = 1'b1;
      seen = {seen[6:0], miso_w};
      #32 tb_sck = 1'b0;
    end
    #32 tb_sa = 1'b1;
    tb_mosi = ~tb_mosi;
    wait_rx;
    `CHECK("slave rx", 32'h0000_0096, rx_data)
    `CHECK("slave tx", 8'h3c, seen)
    rx_ready <= 1'b1;
    $display("slave test done");
  endtask : t_slave
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    repeat (3) @(posedge clock);
    t_modes;
    t_lengths;
    t_fill;
    t_sw;
    t_slave;
    close_out;
  end
  initial begin
    #400000;
    errors++;
    $display("watchdog expired");
    close_out;
  end
endmodule : test_spi_master_slave_controller
